// ---- core/gtf_aux_pin.sv ----
`timescale 1ns/1ps
`include "gtf_map.svh"
// Operation
// RL1 - Reserved-code pin config writes are discarded.
// RL2 - Direction: input, reserved, open-drain, push-pull.
// RL3 - Input: off, edge conversion, edge sequence.
// RL4 - Output: hi-Z, interrupts, constant low/high.
// RL5 - Output: low-side switch, modulator status, clock.
// RL6 - Edge in sleep wakes first, then starts.
// RL7 - Outside holds input levels two clock periods.
// RL8 - Conversion setup write never starts conversion.
// RL9 - Destination field picks result register 0-7.
// RL10 - Kind: single, continuous, duty-cycled low-power.
// RL11 - Sequence address write never starts sequence.
// RL12 - Sequence address accepts only 0x3A..0x6F.
// RL13 - Seven-bit start address, resets to 0x3A.
// RL14 - Software writes zero to filter bit 6.
// RL15 - Filter type: 50/60, 50, 60, sinc4.
// RL16 - Rate field meaning depends on filter type.
// RL17 - Pin sequence starts at stored address.
// RL18 - Synchronise pin, detect rise from samples.
module gtf_aux_pin (
	input  wire logic       REF_CLK,
	input  wire logic       RSTN,
	input  wire logic [7:0] REG_ADDR,
	input  wire logic       REG_WR,
	input  wire logic       REG_RD,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic       GPIO1_IN,
	output logic            GPIO1_OUT,
	output logic            GPIO1_OE,
	input  wire logic       IRQ_ACTIVE,
	input  wire logic       MOD_ACTIVE,
	input  wire logic       LSW_ON,
	input  wire logic [1:0] POWER_STATE,
	output logic            WAKE_REQ,
	output logic            CONV_START,
	output logic      [2:0] CONV_DEST,
	output logic      [1:0] CONV_KIND,
	output logic            SEQ_START,
	output logic      [6:0] SEQ_START_ADDR,
	output logic      [1:0] FILTER_TYPE,
	output logic      [3:0] FILTER_RATE
);
	typedef struct packed {
		gtf_pkg::gtf_pin_cfg_t  cfg;
		logic [2:0]             dest;
		logic [1:0]             kind;
		logic [6:0]             seq_addr;
		logic                   flt_rsvd;
		gtf_pkg::gtf_filter_t   flt_type;
		logic [3:0]             rate;
		logic [7:0]             rdata;
		gtf_pkg::gtf_fsm_t      fsm;
		logic                   pend_seq;
		logic                   wake_req;
		logic                   conv_start;
		logic                   seq_start;
		logic [6:0]             start_addr;
		logic [2:0]             start_dest;
		logic [1:0]             start_kind;
		logic [1:0]             flt_type_o;
		logic [3:0]             rate_o;
	} gtf_top_st_t;

	gtf_top_st_t r;
	gtf_top_st_t next_r;
	logic        rise;
	logic        trig;
	logic        trig_seq;
	logic        pwr_normal;
	logic        wr_cfg_ok;
	logic        wr_seq_ok;

	gtf_pin_if pin_bus ();

	// Pin input is brought onto the clock before any edge decision.
	gtf_edge_sync u_sync (
		.clk    (REF_CLK),
		.rstn   (RSTN),
		.pin_in (GPIO1_IN),
		.rise   (rise)
	);

	// Output function selection and pin drive.
	gtf_pin_drive u_drive (
		.clk  (REF_CLK),
		.rstn (RSTN),
		.pin  (pin_bus.drv)
	);

	assign pin_bus.cfg        = r.cfg;
	assign pin_bus.irq        = IRQ_ACTIVE;
	assign pin_bus.mod_active = MOD_ACTIVE;
	assign pin_bus.lsw_on     = LSW_ON;

	// An edge only counts while the pin is an input with a start function.
	assign trig       = rise && r.cfg.dir == gtf_pkg::GTF_DIR_INPUT &&
		(r.cfg.isel == gtf_pkg::GTF_ISEL_CONV || r.cfg.isel == gtf_pkg::GTF_ISEL_SEQ); // RL3
	assign trig_seq   = r.cfg.isel == gtf_pkg::GTF_ISEL_SEQ; // RL3
	assign pwr_normal = POWER_STATE == gtf_pkg::GTF_PWR_NORMAL;
	// A reserved code in any field rejects the whole write.
	assign wr_cfg_ok  = REG_WDATA[`GTF_DIR_RANGE] != gtf_pkg::GTF_DIR_RSVD &&
		REG_WDATA[`GTF_ISEL_RANGE] != gtf_pkg::GTF_ISEL_RSVD; // RL1
	assign wr_seq_ok  = REG_WDATA >= `GTF_SEQ_ADDR_MIN && REG_WDATA <= `GTF_SEQ_ADDR_MAX; // RL12

	// Register writes, read-back and the trigger sequencer.
	always_comb begin
		next_r            = r;
		next_r.conv_start = 1'b0;
		next_r.seq_start  = 1'b0;
		next_r.flt_type_o = r.flt_type; // RL15
		next_r.rate_o     = r.rate; // RL16
		if (REG_WR) begin
			case (REG_ADDR)
				`GTF_ADDR_PIN_CFG: begin
					if (wr_cfg_ok) begin // RL1
						next_r.cfg.dir  = gtf_pkg::gtf_dir_t'(REG_WDATA[`GTF_DIR_RANGE]); // RL2
						next_r.cfg.isel = gtf_pkg::gtf_isel_t'(REG_WDATA[`GTF_ISEL_RANGE]);
						next_r.cfg.osel = gtf_pkg::gtf_osel_t'(REG_WDATA[`GTF_OSEL_RANGE]);
					end
				end
				`GTF_ADDR_CONV_SETUP: begin
					// Storing only; the start path below never looks at writes.
					next_r.dest = REG_WDATA[`GTF_DEST_RANGE]; // RL8
					next_r.kind = REG_WDATA[`GTF_KIND_RANGE]; // RL10
				end
				`GTF_ADDR_SEQ_START: begin
					if (wr_seq_ok) begin
						next_r.seq_addr = REG_WDATA[`GTF_SEQ_RANGE]; // RL11
					end
				end
				`GTF_ADDR_FILTER: begin
					// Bit 6 is kept as written so software sees what it stored.
					next_r.flt_rsvd = REG_WDATA[`GTF_FLT_RSVD_BIT]; // RL14
					next_r.flt_type = gtf_pkg::gtf_filter_t'(REG_WDATA[`GTF_FLT_TYPE_RANGE]);
					next_r.rate     = REG_WDATA[`GTF_RATE_RANGE]; // RL16
				end
				default: begin
				end
			endcase
		end
		if (REG_RD) begin
			next_r.rdata = `GTF_RDATA_ZERO;
			case (REG_ADDR)
				`GTF_ADDR_PIN_CFG: begin
					next_r.rdata[`GTF_DIR_RANGE]  = r.cfg.dir;
					next_r.rdata[`GTF_ISEL_RANGE] = r.cfg.isel;
					next_r.rdata[`GTF_OSEL_RANGE] = r.cfg.osel;
				end
				`GTF_ADDR_CONV_SETUP: begin
					next_r.rdata[`GTF_DEST_RANGE] = r.dest;
					next_r.rdata[`GTF_KIND_RANGE] = r.kind;
				end
				`GTF_ADDR_SEQ_START: begin
					next_r.rdata[`GTF_SEQ_RANGE] = r.seq_addr;
				end
				`GTF_ADDR_FILTER: begin
					next_r.rdata[`GTF_FLT_RSVD_BIT]   = r.flt_rsvd;
					next_r.rdata[`GTF_FLT_TYPE_RANGE] = r.flt_type;
					next_r.rdata[`GTF_RATE_RANGE]     = r.rate;
				end
				default: begin
				end
			endcase
		end
		// Edges that arrive while waiting for wake-up are dropped.
		case (r.fsm)
			gtf_pkg::GTF_ST_IDLE: begin
				if (trig) begin
					next_r.pend_seq = trig_seq;
					if (pwr_normal) begin
						next_r.conv_start = ~trig_seq;
						next_r.seq_start  = trig_seq;
						next_r.start_addr = r.seq_addr; // RL17
						next_r.start_dest = r.dest; // RL9
						next_r.start_kind = r.kind; // RL10
					end else begin
						next_r.wake_req = 1'b1; // RL6
						next_r.fsm      = gtf_pkg::GTF_ST_WAKE;
					end
				end
			end
			gtf_pkg::GTF_ST_WAKE: begin
				if (pwr_normal) begin
					next_r.wake_req   = 1'b0;
					next_r.conv_start = ~r.pend_seq; // RL6
					next_r.seq_start  = r.pend_seq;
					next_r.start_addr = r.seq_addr; // RL17
					next_r.start_dest = r.dest; // RL9
					next_r.start_kind = r.kind;
					next_r.fsm        = gtf_pkg::GTF_ST_IDLE;
				end
			end
			default: begin
				next_r.wake_req = 1'b0;
				next_r.fsm      = gtf_pkg::GTF_ST_IDLE;
			end
		endcase
	end

	// State register with documented reset values.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			r          <= '0;
			r.cfg      <= `GTF_RST_PIN_CFG; // RL2
			r.seq_addr <= `GTF_RST_SEQ_START; // RL13
			r.flt_type <= gtf_pkg::GTF_FLT_BOTH; // RL15
		end else begin
			r <= next_r;
		end
	end

	assign REG_RDATA      = r.rdata;
	assign GPIO1_OUT      = pin_bus.out;
	assign GPIO1_OE       = pin_bus.oe;
	assign WAKE_REQ       = r.wake_req;
	assign CONV_START     = r.conv_start;
	assign CONV_DEST      = r.start_dest;
	assign CONV_KIND      = r.start_kind;
	assign SEQ_START      = r.seq_start;
	assign SEQ_START_ADDR = r.start_addr;
	assign FILTER_TYPE    = r.flt_type_o;
	assign FILTER_RATE    = r.rate_o;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	AST_CFG_RSVD_DISCARD: assert property ( // RL1
		REG_WR && REG_ADDR == `GTF_ADDR_PIN_CFG && !wr_cfg_ok |=> $stable(r.cfg))
		else $error("Pin config changed on a reserved-code write.");
	AST_INPUT_NOT_DRIVEN: assert property ( // RL2
		r.cfg.dir == gtf_pkg::GTF_DIR_INPUT |=> !GPIO1_OE)
		else $error("Pin driven while configured as input.");
	AST_CONST_LOW_OUT: assert property ( // RL4
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL && r.cfg.osel == gtf_pkg::GTF_OSEL_LOW
		|=> GPIO1_OE && !GPIO1_OUT)
		else $error("Constant low output not driven low.");
	AST_SWITCH_OVERRIDE: assert property ( // RL5
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_LOW_SWITCH && !LSW_ON |=> !GPIO1_OE)
		else $error("Low-side switch drove the pin high.");
	AST_WAKE_BEFORE_START: assert property ( // RL6
		trig && !pwr_normal && r.fsm == gtf_pkg::GTF_ST_IDLE
		|=> WAKE_REQ && !CONV_START && !SEQ_START)
		else $error("Start issued without waking first.");
	AST_WAKE_THEN_START: assert property ( // RL6
		r.fsm == gtf_pkg::GTF_ST_WAKE && pwr_normal |=> (CONV_START || SEQ_START) && !WAKE_REQ)
		else $error("No start after wake-up completed.");
	AST_SETUP_NO_START: assert property ( // RL8
		REG_WR && REG_ADDR == `GTF_ADDR_CONV_SETUP && !trig &&
		r.fsm == gtf_pkg::GTF_ST_IDLE |=> !CONV_START)
		else $error("Setup write launched a conversion.");
	AST_DEST_CAPTURED: assert property ( // RL9
		CONV_START |-> CONV_DEST == $past(r.dest) && CONV_KIND == $past(r.kind))
		else $error("Conversion destination not taken from setup.");
	AST_SEQ_RANGE: assert property ( // RL12
		REG_WR && REG_ADDR == `GTF_ADDR_SEQ_START && !wr_seq_ok |=> $stable(r.seq_addr))
		else $error("Out-of-range sequence address was stored.");
	AST_SEQ_FROM_REG: assert property ( // RL17
		SEQ_START |-> SEQ_START_ADDR == $past(r.seq_addr))
		else $error("Sequence start address differs from stored value.");
	AST_FILTER_FOLLOWS: assert property ( // RL15
		REG_WR && REG_ADDR == `GTF_ADDR_FILTER ##1 !(REG_WR && REG_ADDR == `GTF_ADDR_FILTER)
		|=> FILTER_TYPE == $past(REG_WDATA[`GTF_FLT_TYPE_RANGE], 2))
		else $error("Filter type output did not follow the write.");

	// Start decisions: an edge acts only in the mode that the input field selects.
	AST_OFF_NO_START: assert property ( // RL3
		r.cfg.isel == gtf_pkg::GTF_ISEL_OFF && r.fsm == gtf_pkg::GTF_ST_IDLE
		|=> !CONV_START && !SEQ_START)
		else $error("Start issued with the pin input disabled.");
	AST_CONV_ON_EDGE: assert property ( // RL3
		trig && !trig_seq && pwr_normal && r.fsm == gtf_pkg::GTF_ST_IDLE
		|=> CONV_START && !SEQ_START)
		else $error("Conversion edge did not give one conversion start.");
	AST_SEQ_ON_EDGE: assert property ( // RL3
		trig && trig_seq && pwr_normal && r.fsm == gtf_pkg::GTF_ST_IDLE
		|=> SEQ_START && !CONV_START)
		else $error("Sequence edge did not give one sequence start.");
	AST_EDGE_NEEDS_INPUT: assert property ( // RL3
		r.cfg.dir != gtf_pkg::GTF_DIR_INPUT && r.fsm == gtf_pkg::GTF_ST_IDLE
		|=> !CONV_START && !SEQ_START)
		else $error("Start issued while the pin is an output.");
	AST_ASLEEP_HOLDS: assert property ( // RL6
		r.fsm == gtf_pkg::GTF_ST_WAKE && !pwr_normal
		|=> WAKE_REQ && !CONV_START && !SEQ_START)
		else $error("Start issued before normal power returned.");

	// Register stores: a legal write lands at its edge and changes nothing else.
	AST_SETUP_STORED: assert property ( // RL10
		REG_WR && REG_ADDR == `GTF_ADDR_CONV_SETUP
		|=> r.kind == $past(REG_WDATA[`GTF_KIND_RANGE]) &&
		r.dest == $past(REG_WDATA[`GTF_DEST_RANGE]))
		else $error("Conversion setup write not stored.");
	AST_SEQ_WRITE_NO_START: assert property ( // RL11
		REG_WR && REG_ADDR == `GTF_ADDR_SEQ_START && !trig &&
		r.fsm == gtf_pkg::GTF_ST_IDLE |=> !SEQ_START)
		else $error("Sequence address write started a sequence.");
	AST_SEQ_STORED: assert property ( // RL13
		REG_WR && REG_ADDR == `GTF_ADDR_SEQ_START && wr_seq_ok
		|=> r.seq_addr == $past(REG_WDATA[`GTF_SEQ_RANGE]))
		else $error("In-range sequence address not stored.");
	AST_CFG_STORED: assert property ( // RL1
		REG_WR && REG_ADDR == `GTF_ADDR_PIN_CFG && wr_cfg_ok
		|=> r.cfg.osel == $past(REG_WDATA[`GTF_OSEL_RANGE]) &&
		r.cfg.isel == $past(REG_WDATA[`GTF_ISEL_RANGE]))
		else $error("Legal pin config write not stored.");
	AST_RATE_FOLLOWS: assert property ( // RL16
		REG_WR && REG_ADDR == `GTF_ADDR_FILTER
		|-> ##2 FILTER_RATE == $past(REG_WDATA[`GTF_RATE_RANGE], 2))
		else $error("Filter rate output did not follow the write.");

	// Pin outputs: the driver registers its decision, so each check looks one edge on.
	AST_HIZ_RELEASED: assert property ( // RL4
		r.cfg.osel == gtf_pkg::GTF_OSEL_HIZ |=> !GPIO1_OE)
		else $error("Pin driven with output disabled.");
	AST_CONST_HIGH_OUT: assert property ( // RL4
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_HIGH
		|=> GPIO1_OE && GPIO1_OUT)
		else $error("Constant high output not driven high.");
	AST_IRQ_LOW_OUT: assert property ( // RL4
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_IRQ_LOW
		|=> GPIO1_OE && GPIO1_OUT == !$past(IRQ_ACTIVE))
		else $error("Active-low interrupt output has the wrong level.");
	AST_IRQ_HIGH_OUT: assert property ( // RL4
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_IRQ_HIGH
		|=> GPIO1_OE && GPIO1_OUT == $past(IRQ_ACTIVE))
		else $error("Active-high interrupt output has the wrong level.");
	AST_OPEN_DRAIN_LOW: assert property ( // RL2
		r.cfg.dir == gtf_pkg::GTF_DIR_OPEN_DRAIN |=> !GPIO1_OUT)
		else $error("Open-drain pin driven high.");
	AST_MOD_STATUS_OUT: assert property ( // RL5
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_MOD_ACTIVE
		|=> GPIO1_OE && GPIO1_OUT == $past(MOD_ACTIVE))
		else $error("Modulator status not shown on the pin.");
	AST_SWITCH_PULLS_LOW: assert property ( // RL5
		r.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
		r.cfg.osel == gtf_pkg::GTF_OSEL_LOW_SWITCH && LSW_ON
		|=> GPIO1_OE && !GPIO1_OUT)
		else $error("Low-side switch did not pull the pin low.");

	COV_CONV_START: cover property (trig && !trig_seq ##1 CONV_START);
	COV_SEQ_START: cover property (trig && trig_seq ##1 SEQ_START);
	COV_WAKE_PATH: cover property (WAKE_REQ ##[1:20] (CONV_START || SEQ_START));
	COV_RSVD_WRITE: cover property (REG_WR && REG_ADDR == `GTF_ADDR_PIN_CFG && !wr_cfg_ok);
endmodule // gtf_aux_pin

// ---- core/gtf_map.svh ----
`ifndef GTF_MAP_SVH
`define GTF_MAP_SVH

// Register offsets on the register port.
`define GTF_ADDR_PIN_CFG      8'h05
`define GTF_ADDR_CONV_SETUP   8'h06
`define GTF_ADDR_SEQ_START    8'h07
`define GTF_ADDR_FILTER       8'h08

// Reset values.
`define GTF_RST_PIN_CFG       7'h00
`define GTF_RST_CONV_SETUP    8'h00
`define GTF_RST_SEQ_START     7'h3a
`define GTF_RST_FILTER        8'h00
`define GTF_RDATA_ZERO        8'h00

// Field positions.
`define GTF_DIR_RANGE         7:6
`define GTF_ISEL_RANGE        5:4
`define GTF_OSEL_RANGE        2:0
`define GTF_DEST_RANGE        6:4
`define GTF_KIND_RANGE        1:0
`define GTF_SEQ_RANGE         6:0
`define GTF_FLT_RSVD_BIT      6
`define GTF_FLT_TYPE_RANGE    5:4
`define GTF_RATE_RANGE        3:0

// Accepted window of pin-triggered sequence start addresses.
`define GTF_SEQ_ADDR_MIN      8'h3a
`define GTF_SEQ_ADDR_MAX      8'h6f

// Timing: clock period and half period of the nominal system clock.
`define GTF_CLK_PERIOD_PS     25000
`define GTF_SYSCLK_HALF_PS    203583
`define GTF_SYSCLK_HALF_CYC   (`GTF_SYSCLK_HALF_PS / `GTF_CLK_PERIOD_PS)

`endif

// ---- core/gtf_pkg.sv ----
package gtf_pkg;
	typedef enum logic [1:0] {GTF_DIR_INPUT = 2'h0, GTF_DIR_RSVD = 2'h1,
		GTF_DIR_OPEN_DRAIN = 2'h2, GTF_DIR_PUSH_PULL = 2'h3} gtf_dir_t;
	typedef enum logic [1:0] {GTF_ISEL_OFF = 2'h0, GTF_ISEL_CONV = 2'h1,
		GTF_ISEL_SEQ = 2'h2, GTF_ISEL_RSVD = 2'h3} gtf_isel_t;
	typedef enum logic [2:0] {GTF_OSEL_HIZ = 3'h0, GTF_OSEL_IRQ_LOW = 3'h1,
		GTF_OSEL_IRQ_HIGH = 3'h2, GTF_OSEL_LOW = 3'h3, GTF_OSEL_HIGH = 3'h4,
		GTF_OSEL_LOW_SWITCH = 3'h5, GTF_OSEL_MOD_ACTIVE = 3'h6,
		GTF_OSEL_SYSCLK = 3'h7} gtf_osel_t;
	typedef enum logic [1:0] {GTF_PWR_NORMAL = 2'h0, GTF_PWR_STANDBY = 2'h1,
		GTF_PWR_SLEEP = 2'h2, GTF_PWR_OTHER = 2'h3} gtf_power_t;
	typedef enum logic [1:0] {GTF_ST_IDLE = 2'h0, GTF_ST_WAKE = 2'h1,
		GTF_ST_SPARE = 2'h2} gtf_fsm_t;
	typedef enum logic [1:0] {GTF_FLT_BOTH = 2'h0, GTF_FLT_50HZ = 2'h1,
		GTF_FLT_60HZ = 2'h2, GTF_FLT_SINC4 = 2'h3} gtf_filter_t;
	typedef struct packed {
		gtf_dir_t  dir;
		gtf_isel_t isel;
		gtf_osel_t osel;
	} gtf_pin_cfg_t;
endpackage

// ---- core/gtf_pin_if.sv ----
`timescale 1ns/1ps
// Carries the pin configuration and status sources to the pin driver.
interface gtf_pin_if;
	gtf_pkg::gtf_pin_cfg_t cfg;
	logic                  irq;
	logic                  mod_active;
	logic                  lsw_on;
	logic                  out;
	logic                  oe;
	modport drv (input cfg, input irq, input mod_active, input lsw_on, output out, output oe);
	modport ctl (output cfg, output irq, output mod_active, output lsw_on, input out, input oe);
endinterface // gtf_pin_if

// ---- core/gtf_edge_sync.sv ----
`timescale 1ns/1ps
module gtf_edge_sync (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin_in,
	output logic      rise
);
	typedef struct packed {
		logic meta;
		logic sync;
		logic last;
		logic rise;
	} gtf_sync_st_t;

	gtf_sync_st_t r;
	gtf_sync_st_t next_r;

	// Two stages settle the pin; only the second stage feeds the comparison.
	always_comb begin
		next_r      = r;
		next_r.meta = pin_in;
		next_r.sync = r.meta;
		next_r.last = r.sync;
		next_r.rise = r.sync & ~r.last; // RL18
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign rise = r.rise;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_RISE_FROM_SAMPLES: assert property (rise |-> $past(r.sync) && !$past(r.last)) // RL18
		else $error("Rise pulse without a low-to-high sample pair.");
endmodule // gtf_edge_sync

// ---- core/gtf_pin_drive.sv ----
`timescale 1ns/1ps
`include "gtf_map.svh"
module gtf_pin_drive (
	input  wire logic clk,
	input  wire logic rstn,
	gtf_pin_if.drv    pin
);
	typedef struct packed {
		logic       out;
		logic       oe;
		logic       sysclk;
		logic [3:0] div;
	} gtf_drv_st_t;

	gtf_drv_st_t r;
	gtf_drv_st_t next_r;
	logic        level;

	// The divided clock is coarse: it only approximates the nominal rate.
	always_comb begin
		next_r = r;
		level  = 1'b0;
		if (r.div == 4'(`GTF_SYSCLK_HALF_CYC - 1)) begin
			next_r.div    = '0;
			next_r.sysclk = ~r.sysclk;
		end else begin
			next_r.div = r.div + 4'h1;
		end
		case (pin.cfg.osel) // RL4
			gtf_pkg::GTF_OSEL_IRQ_LOW:    level = ~pin.irq;
			gtf_pkg::GTF_OSEL_IRQ_HIGH:   level = pin.irq;
			gtf_pkg::GTF_OSEL_LOW:        level = 1'b0;
			gtf_pkg::GTF_OSEL_HIGH:       level = 1'b1;
			gtf_pkg::GTF_OSEL_LOW_SWITCH: level = ~pin.lsw_on; // RL5
			gtf_pkg::GTF_OSEL_MOD_ACTIVE: level = pin.mod_active; // RL5
			gtf_pkg::GTF_OSEL_SYSCLK:     level = r.sysclk; // RL5
			default:                      level = 1'b0;
		endcase
		// Open drain only ever pulls low; the low-side switch forces that mode.
		next_r.out = 1'b0;
		next_r.oe  = 1'b0;
		if (pin.cfg.osel != gtf_pkg::GTF_OSEL_HIZ) begin
			if (pin.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL &&
				pin.cfg.osel != gtf_pkg::GTF_OSEL_LOW_SWITCH) begin // RL2
				next_r.out = level;
				next_r.oe  = 1'b1;
			end else if (pin.cfg.dir == gtf_pkg::GTF_DIR_PUSH_PULL ||
				pin.cfg.dir == gtf_pkg::GTF_DIR_OPEN_DRAIN) begin // RL2
				next_r.oe = ~level;
			end
		end
	end

	// State register.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign pin.out = r.out;
	assign pin.oe  = r.oe;
endmodule // gtf_pin_drive

// ---- testbench/gtf_pin_partner.sv ----
`timescale 1ns/1ps
// Stands in for the external logic on the pin: it drives pulses and senses the wire.
module gtf_pin_partner (
	input  wire logic clk,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_in,
	output logic      pin_level
);
	logic drive;
	logic drive_en;

	// A released wire floats up through the pull-up instead of keeping its last level.
	assign pin_level = (pin_oe === 1'b1) ? pin_out : (drive_en ? drive : 1'b1);
	assign pin_in = pin_level;

	// The partner starts out driving a low level.
	initial begin
		drive = 1'b0;
		drive_en = 1'b1;
	end

	// The high level is held for at least two clock periods so the device can see it.
	task automatic pulse(input int hi);
		@(negedge clk);
		drive_en = 1'b1;
		drive = 1'b1;
		repeat ((hi < 2) ? 2 : hi) @(negedge clk);
		drive = 1'b0;
	endtask

	// Lets go of the wire while the device drives the pin.
	task automatic release_pin();
		@(negedge clk);
		drive_en = 1'b0;
	endtask
endmodule // gtf_pin_partner

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the auxiliary pin block.
module tb;
	logic       ref_clk;
	logic       rstn;
	logic [7:0] reg_addr;
	logic       reg_wr;
	logic       reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic       gpio_in;
	logic       gpio_out;
	logic       gpio_oe;
	logic       pin_level;
	logic       irq_active;
	logic       mod_active;
	logic       lsw_on;
	logic [1:0] power_state;
	logic       wake_req;
	logic       conv_start;
	logic [2:0] conv_dest;
	logic [1:0] conv_kind;
	logic       seq_start;
	logic [6:0] seq_start_addr;
	logic [1:0] filter_type;
	logic [3:0] filter_rate;
	int         bad_count;
	int         checks;
	int         conv_n;
	int         seq_n;
	int         tog_n;
	logic [7:0] ocfg [11] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc6, 8'h84, 8'h83,
		8'hc5, 8'h80, 8'hc2};
	logic [1:0] oexp [11] = '{2'h0, 2'h2, 2'h3, 2'h2, 2'h3, 2'h3, 2'h0, 2'h2, 2'h2,
		2'h0, 2'h2};

	gtf_aux_pin i_gtf_aux_pin (.REF_CLK(ref_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
		.REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.GPIO1_IN(gpio_in), .GPIO1_OUT(gpio_out), .GPIO1_OE(gpio_oe),
		.IRQ_ACTIVE(irq_active), .MOD_ACTIVE(mod_active), .LSW_ON(lsw_on),
		.POWER_STATE(power_state), .WAKE_REQ(wake_req), .CONV_START(conv_start),
		.CONV_DEST(conv_dest), .CONV_KIND(conv_kind), .SEQ_START(seq_start),
		.SEQ_START_ADDR(seq_start_addr), .FILTER_TYPE(filter_type),
		.FILTER_RATE(filter_rate));

	gtf_pin_partner i_gtf_pin_partner (.clk(ref_clk), .pin_out(gpio_out),
		.pin_oe(gpio_oe), .pin_in(gpio_in), .pin_level(pin_level));

	// The clock runs at 40 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// Start pulses are counted so that a doubled or missing start shows up.
	always @(posedge ref_clk) begin
		if (conv_start === 1'b1) conv_n++;
		if (seq_start === 1'b1) seq_n++;
	end

	// Every change of the pin output is counted for the clock output mode.
	always @(gpio_out) tog_n++;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// One write strobe, held for exactly one rising edge.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge ref_clk);
		reg_wr = 1'b0;
	endtask

	// Read data is registered, so it is looked at one edge after the strobe.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge ref_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge ref_clk);
		reg_rd = 1'b0;
		@(negedge ref_clk);
		chk(reg_rdata, exp, "register read");
	endtask

	// Sends one pin pulse and checks how many starts of each kind followed.
	task automatic trig(input int ec, input int es);
		int c0;
		int s0;
		c0 = conv_n;
		s0 = seq_n;
		i_gtf_pin_partner.pulse(2);
		cyc(10);
		chk(8'(conv_n - c0), 8'(ec), "conversion starts");
		chk(8'(seq_n - s0), 8'(es), "sequence starts");
	endtask

	// A hang is cut short well beyond the expected run length.
	initial begin
		#(25 * 40000);
		bad_count++;
		$display("ERROR %0t: watchdog expired", $time);
		stop_test();
	end

	// Main sequence of tests.
	initial begin
		logic [7:0] d;
		int         c0;
		int         s0;
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		irq_active = 1'b0;
		mod_active = 1'b0;
		lsw_on = 1'b0;
		power_state = 2'h0;
		bad_count = 0;
		checks = 0;
		rstn = 1'b0;
		cyc(16);
		rstn = 1'b1;
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		rd(8'h07, 8'h3a);
		rd(8'h08, 8'h00);
		rd(8'h20, 8'h00);
		$display("test reset values done");
		wr(8'h05, 8'h12);
		rd(8'h05, 8'h12);
		wr(8'h05, 8'h44);
		rd(8'h05, 8'h12);
		wr(8'h05, 8'h34);
		rd(8'h05, 8'h12);
		$display("test reserved codes done");
		wr(8'h07, 8'h39);
		rd(8'h07, 8'h3a);
		wr(8'h07, 8'h70);
		rd(8'h07, 8'h3a);
		wr(8'h07, 8'h6f);
		rd(8'h07, 8'h6f);
		chk(8'(seq_n), 8'h00, "start on address write");
		$display("test sequence address window done");
		wr(8'h05, 8'h10);
		for (int i = 0; i < 8; i++) begin
			d = {1'b0, 3'(i), 2'b00, 2'(i)};
			c0 = conv_n;
			wr(8'h06, d);
			rd(8'h06, d);
			chk(8'(conv_n - c0), 8'h00, "start on setup write");
			trig(1, 0);
			chk(8'(conv_dest), 8'(i % 8), "destination");
			chk(8'(conv_kind), 8'(i % 4), "conversion kind");
		end
		$display("test conversion trigger done");
		wr(8'h07, 8'h55);
		wr(8'h05, 8'h20);
		trig(0, 1);
		chk(8'(seq_start_addr), 8'h55, "sequence address");
		wr(8'h05, 8'h00);
		trig(0, 0);
		wr(8'h05, 8'hd0);
		trig(0, 0);
		$display("test sequence trigger done");
		wr(8'h05, 8'h10);
		for (int p = 1; p < 4; p++) begin
			if (p == 3) wr(8'h05, 8'h20);
			power_state = 2'(p);
			trig(0, 0);
			chk(8'(wake_req), 8'h01, "wake request");
			c0 = conv_n;
			s0 = seq_n;
			power_state = 2'h0;
			cyc(10);
			chk(8'(wake_req), 8'h00, "wake release");
			chk(8'(conv_n - c0), 8'(p < 3), "start after wake");
			chk(8'(seq_n - s0), 8'(p == 3), "sequence after wake");
		end
		chk(8'(seq_start_addr), 8'h55, "sequence address after wake");
		$display("test wake from low power done");
		for (int i = 0; i < 4; i++) begin
			d = {2'b00, 2'(i), 4'(i * 5)};
			wr(8'h08, d);
			cyc(2);
			chk(8'(filter_type), 8'(i), "filter type");
			chk(8'(filter_rate), 8'(i * 5), "filter rate");
			rd(8'h08, d);
		end
		$display("test filter select done");
		i_gtf_pin_partner.release_pin();
		mod_active = 1'b1;
		lsw_on = 1'b1;
		for (int i = 0; i < 11; i++) begin
			irq_active = (i < 10);
			wr(8'h05, ocfg[i]);
			cyc(3);
			chk(8'({gpio_oe, gpio_out}), 8'(oexp[i]), "pin output");
		end
		wr(8'h05, 8'hc7);
		cyc(4);
		tog_n = 0;
		cyc(64);
		chk(8'(tog_n), 8'h08, "clock output toggles");
		$display("test output functions done");
		stop_test();
	end
endmodule // tb
